// ===== sim/qsg_monitor_model.sv
// Behavioural loss monitors of the error detector and pattern generator
`timescale 1ns/100ps
module qsg_monitor_model (
  input  wire logic [8:0] lost_i,
  output logic            ed_clock_lost_o,
  output logic            pg_clock_lost_o,
  output logic            ed_data_lost_o,
  output logic            ed_threshold_outside_eye_o,
  output logic            ed_power_lost_o,
  output logic            pg_power_lost_o,
  output logic            calibration_mismatch_o,
  output logic            pattern_mismatch_o,
  output logic            error_rate_over_sync_o
);
  // Levels hold for as long as the loss lasts; they are not pulses
  assign ed_clock_lost_o            = lost_i[0];
  assign pg_clock_lost_o            = lost_i[1];
  assign ed_data_lost_o             = lost_i[2];
  assign ed_threshold_outside_eye_o = lost_i[3];
  assign ed_power_lost_o            = lost_i[4];
  assign pg_power_lost_o            = lost_i[5];
  assign calibration_mismatch_o     = lost_i[6];
  assign pattern_mismatch_o         = lost_i[7];
  assign error_rate_over_sync_o     = lost_i[8];
endmodule // qsg_monitor_model

// ===== sim/qsg_top_properties.sv
// Concurrent checks on the command port and summaries of the status groups
`timescale 1ns/100ps
`include "qsg_map.svh"
module qsg_top_properties
  import qsg_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               cmd_valid_i,
  input  wire logic               cmd_write_i,
  input  wire qsg_pkg::qsg_sel_t  cmd_sel_i,
  input  wire logic               rsp_valid_o,
  input  wire qsg_pkg::qsg_word_t rsp_data_o,
  input  wire logic               clock_loss_summary_o,
  input  wire logic               doubt_summary_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire rd_take = cmd_valid_i && !cmd_write_i;

  chk_read_answers: assert property (rd_take |=> rsp_valid_o)
    else $error("read command got no answer");
  chk_no_stray_rsp: assert property (!rd_take |=> !rsp_valid_o)
    else $error("answer without a read command");
  chk_data_holds: assert property (!rsp_valid_o |-> $stable(rsp_data_o))
    else $error("read data moved without an answer");
  chk_cl_unused_zero: assert property (rsp_valid_o && $past(cmd_sel_i) <= 4'h4 |->
    (rsp_data_o & ~`QSG_CL_USED) == 16'h0000) else $error("clock-loss unused bit read high");
  chk_md_unused_zero: assert property (rsp_valid_o && $past(cmd_sel_i) inside {[4'h5:4'h9]} |->
    (rsp_data_o & ~`QSG_MD_USED) == 16'h0000) else $error("doubt unused bit read high");
  chk_unmapped_zero: assert property (rsp_valid_o && $past(cmd_sel_i) > 4'h9 |->
    rsp_data_o == 16'h0000) else $error("unmapped select read nonzero");
  chk_clock_bit_pair: assert property (rsp_valid_o && $past(cmd_sel_i) == 4'h5 |->
    rsp_data_o[5] == rsp_data_o[9]) else $error("doubt clock bits differ");
  // Latched events only go away by command, so a summary may only fall two edges after one
  chk_cl_sum_fall: assert property ($fell(clock_loss_summary_o) |-> $past(cmd_valid_i, 2))
    else $error("clock-loss summary fell without a command");
  chk_md_sum_fall: assert property ($fell(doubt_summary_o) |-> $past(cmd_valid_i, 2))
    else $error("doubt summary fell without a command");

  cover property (rd_take ##1 rsp_valid_o);
  cover property ($rose(clock_loss_summary_o));
  cover property ($rose(doubt_summary_o));
endmodule // qsg_top_properties

bind qsg_top qsg_top_properties i_props (
  .clk_i                (clk_i),
  .rst_b_i              (rst_b_i),
  .cmd_valid_i          (cmd_valid_i),
  .cmd_write_i          (cmd_write_i),
  .cmd_sel_i            (cmd_sel_i),
  .rsp_valid_o          (rsp_valid_o),
  .rsp_data_o           (rsp_data_o),
  .clock_loss_summary_o (clock_loss_summary_o),
  .doubt_summary_o      (doubt_summary_o)
);

// ===== sim/qsg_top_tb_top.sv
// Command-level testbench of the status groups
`timescale 1ns/100ps
`include "qsg_map.svh"
module qsg_top_tb_top;
  import qsg_pkg::*;
  logic      clk_i       = 1'b0;
  logic      rst_b_i     = 1'b0;
  logic      cmd_valid_i = 1'b0;
  logic      cmd_write_i = 1'b0;
  qsg_sel_t  cmd_sel_i   = 4'h0;
  qsg_word_t cmd_wdata_i = 16'h0000;
  logic [8:0] lost       = 9'h000;
  wire  [8:0] pin;
  logic      rsp_valid_o;
  qsg_word_t rsp_data_o;
  logic      clock_loss_summary_o;
  logic      doubt_summary_o;
  int        err_count   = 0;
  int        cmp_count   = 0;
  qsg_word_t src_exp [2:8] = '{16'h0001, 16'h0001, 16'h0008, 16'h0008, 16'h0100, 16'h0400, 16'h0400};

  always #2.5 clk_i = ~clk_i;

  qsg_monitor_model i_mon (
    .lost_i                     (lost),
    .ed_clock_lost_o            (pin[0]),
    .pg_clock_lost_o            (pin[1]),
    .ed_data_lost_o             (pin[2]),
    .ed_threshold_outside_eye_o (pin[3]),
    .ed_power_lost_o            (pin[4]),
    .pg_power_lost_o            (pin[5]),
    .calibration_mismatch_o     (pin[6]),
    .pattern_mismatch_o         (pin[7]),
    .error_rate_over_sync_o     (pin[8])
  );

  qsg_top i_dut (
    .clk_i                      (clk_i),
    .rst_b_i                    (rst_b_i),
    .ed_clock_lost_i            (pin[0]),
    .pg_clock_lost_i            (pin[1]),
    .ed_data_lost_i             (pin[2]),
    .ed_threshold_outside_eye_i (pin[3]),
    .ed_power_lost_i            (pin[4]),
    .pg_power_lost_i            (pin[5]),
    .calibration_mismatch_i     (pin[6]),
    .pattern_mismatch_i         (pin[7]),
    .error_rate_over_sync_i     (pin[8]),
    .cmd_valid_i                (cmd_valid_i),
    .cmd_write_i                (cmd_write_i),
    .cmd_sel_i                  (cmd_sel_i),
    .cmd_wdata_i                (cmd_wdata_i),
    .rsp_valid_o                (rsp_valid_o),
    .rsp_data_o                 (rsp_data_o),
    .clock_loss_summary_o       (clock_loss_summary_o),
    .doubt_summary_o            (doubt_summary_o)
  );

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input qsg_word_t seen, input qsg_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic wr(input qsg_sel_t sel, input qsg_word_t data);
    @(posedge clk_i); #1;
    cmd_valid_i = 1'b1; cmd_write_i = 1'b1; cmd_sel_i = sel; cmd_wdata_i = data;
    @(posedge clk_i); #1;
    cmd_valid_i = 1'b0;
  endtask

  // The answer is registered at the edge that takes the command, so it is looked at just after that edge
  task automatic rd(input qsg_sel_t sel, input qsg_word_t exp);
    @(posedge clk_i); #1;
    cmd_valid_i = 1'b1; cmd_write_i = 1'b0; cmd_sel_i = sel;
    @(posedge clk_i); #1;
    cmd_valid_i = 1'b0;
    flag(rsp_valid_o, 1'b1);
    check(rsp_data_o, exp);
  endtask

  // Pin to doubt summary takes eight edges through the synchroniser and both groups
  task automatic set_lost(input logic [8:0] v);
    @(posedge clk_i); #1;
    lost = v;
    repeat (10) @(posedge clk_i);
    #1;
  endtask

  initial begin
    #100000;
    err_count++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk_i); #1;
    rst_b_i = 1'b1;
    rd(QSG_CL_RISE, `QSG_CL_RISE_RST);
    rd(QSG_CL_FALL, `QSG_FALL_RST);
    rd(QSG_MD_RISE, `QSG_MD_RISE_RST);
    rd(QSG_MD_FALL, `QSG_FALL_RST);
    rd(QSG_CL_ENABLE, `QSG_ENABLE_RST);
    rd(QSG_MD_COND, `QSG_ZERO16);
    rd(4'hb, `QSG_ZERO16);
    wr(QSG_MD_FALL, 16'hffff);
    rd(QSG_MD_FALL, `QSG_MD_USED);
    wr(QSG_CL_FALL, 16'hffff);
    rd(QSG_CL_FALL, `QSG_CL_USED);
    wr(QSG_MD_FALL, 16'h0400);
    rd(QSG_MD_FALL, 16'h0400);
    wr(QSG_CL_FALL, 16'h0000);
    wr(QSG_MD_COND, 16'hffff);
    rd(QSG_MD_COND, `QSG_ZERO16);
    set_lost(9'h001);
    rd(QSG_CL_COND, 16'h0001);
    rd(QSG_CL_EVENT, 16'h0001);
    rd(QSG_CL_EVENT, `QSG_ZERO16);
    flag(clock_loss_summary_o, 1'b0);
    wr(QSG_CL_ENABLE, 16'h0003);
    set_lost(9'h003);
    rd(QSG_CL_COND, 16'h0003);
    flag(clock_loss_summary_o, 1'b1);
    rd(QSG_MD_COND, 16'h0220);
    rd(QSG_CL_EVENT, 16'h0002);
    @(posedge clk_i); #1;
    flag(clock_loss_summary_o, 1'b0);
    rd(QSG_MD_EVENT, 16'h0220);
    set_lost(9'h000);
    rd(QSG_MD_EVENT, `QSG_ZERO16);
    rd(QSG_CL_EVENT, `QSG_ZERO16);
    // Each doubt source alone, so a swapped bit position shows up
    for (int i = 2; i <= 8; i++) begin
      set_lost(9'h001 << i);
      rd(QSG_MD_COND, src_exp[i]);
      set_lost(9'h000);
    end
    rd(QSG_MD_EVENT, 16'h0509);
    wr(QSG_MD_RISE, 16'h0000);
    wr(QSG_MD_ENABLE, 16'h0400);
    set_lost(9'h080);
    rd(QSG_MD_EVENT, `QSG_ZERO16);
    flag(doubt_summary_o, 1'b0);
    set_lost(9'h000);
    flag(doubt_summary_o, 1'b1);
    wr(QSG_CLEAR_ALL, 16'h0000);
    @(posedge clk_i); #1;
    flag(doubt_summary_o, 1'b0);
    rd(QSG_MD_EVENT, `QSG_ZERO16);
    // Clock-loss filter set to pass only a falling edge on the pattern generator bit
    wr(QSG_CL_RISE, 16'h0000);
    wr(QSG_CL_FALL, 16'h0002);
    set_lost(9'h002);
    rd(QSG_CL_EVENT, `QSG_ZERO16);
    set_lost(9'h000);
    flag(clock_loss_summary_o, 1'b1);
    rd(QSG_CL_EVENT, 16'h0002);
    @(posedge clk_i); #1;
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i); #1;
    rst_b_i = 1'b1;
    rd(QSG_MD_RISE, `QSG_MD_RISE_RST);
    rd(QSG_MD_ENABLE, `QSG_ENABLE_RST);
    final_report();
  end
endmodule // qsg_top_tb_top

// ===== src/qsg_edge_group.sv
// Condition, transition filter and latching event register of one group
`timescale 1ns/100ps
module qsg_edge_group #(
  parameter logic [15:0] USED = 16'hffff
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] cond_i,
  input  wire logic [15:0] rise_mask_i,
  input  wire logic [15:0] fall_mask_i,
  input  wire logic        event_clr_i,
  output logic      [15:0] cond_o,
  output logic      [15:0] event_o
);
  logic [15:0] cond_r;
  logic [15:0] prev_r;
  logic [15:0] event_r;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] pass;
  logic [15:0] event_nxt;

  // Edges come from the current and previous sampled condition
  assign rise      = cond_r & ~prev_r;                                 // RULE21
  assign fall      = ~cond_r & prev_r;                                 // RULE21
  assign pass      = (rise & rise_mask_i) | (fall & fall_mask_i);      // RULE8
  // New events win over a clear in the same cycle
  assign event_nxt = ((event_r & ~{16{event_clr_i}}) | pass) & USED;   // RULE22

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cond_r  <= 16'h0000;
      prev_r  <= 16'h0000;
      event_r <= 16'h0000;
    end else begin
      cond_r  <= cond_i & USED;                                        // RULE21
      prev_r  <= cond_r;
      event_r <= event_nxt;                                            // RULE5
    end
  end

  assign cond_o  = cond_r;
  assign event_o = event_r;
endmodule // qsg_edge_group

// ===== src/qsg_map.svh
// Register selects, field positions and reset values of the status groups
`ifndef QSG_MAP_SVH
`define QSG_MAP_SVH

// Register select codes carried on the command port
`define QSG_SEL_CL_COND      4'h0
`define QSG_SEL_CL_RISE      4'h1
`define QSG_SEL_CL_FALL      4'h2
`define QSG_SEL_CL_EVENT     4'h3
`define QSG_SEL_CL_ENABLE    4'h4
`define QSG_SEL_MD_COND      4'h5
`define QSG_SEL_MD_RISE      4'h6
`define QSG_SEL_MD_FALL      4'h7
`define QSG_SEL_MD_EVENT     4'h8
`define QSG_SEL_MD_ENABLE    4'h9
`define QSG_SEL_CLEAR_ALL    4'ha

// Clock-loss group bit positions
`define QSG_CL_ED_BIT        0
`define QSG_CL_PG_BIT        1

// Measurement-doubt group bit positions
`define QSG_MD_DATA_LOSS_BIT 0
`define QSG_MD_POWER_BIT     3
`define QSG_MD_CLOCK_A_BIT   5
`define QSG_MD_CALIBRATION_MISMATCH_BIT     8
`define QSG_MD_CLOCK_B_BIT   9
`define QSG_MD_SYNC_BIT      10

// Implemented bits per group; all others read zero
`define QSG_CL_USED          16'h0003
`define QSG_MD_USED          16'h0729

// Reset values: rising edges pass, falling edges blocked, nothing enabled
`define QSG_CL_RISE_RST      16'h0003
`define QSG_MD_RISE_RST      16'h0729
`define QSG_FALL_RST         16'h0000
`define QSG_ENABLE_RST       16'h0000
`define QSG_ZERO16           16'h0000

`endif

// ===== src/qsg_pkg.sv
// Types shared by the status group design
`include "qsg_map.svh"
package qsg_pkg;
  typedef logic [15:0] qsg_word_t;
  typedef logic [3:0]  qsg_sel_t;

  typedef enum logic [3:0] {
    QSG_CL_COND   = `QSG_SEL_CL_COND,
    QSG_CL_RISE   = `QSG_SEL_CL_RISE,
    QSG_CL_FALL   = `QSG_SEL_CL_FALL,
    QSG_CL_EVENT  = `QSG_SEL_CL_EVENT,
    QSG_CL_ENABLE = `QSG_SEL_CL_ENABLE,
    QSG_MD_COND   = `QSG_SEL_MD_COND,
    QSG_MD_RISE   = `QSG_SEL_MD_RISE,
    QSG_MD_FALL   = `QSG_SEL_MD_FALL,
    QSG_MD_EVENT  = `QSG_SEL_MD_EVENT,
    QSG_MD_ENABLE = `QSG_SEL_MD_ENABLE,
    QSG_CLEAR_ALL = `QSG_SEL_CLEAR_ALL
  } qsg_sel_e;
endpackage

// ===== src/qsg_sync.sv
// Two-stage synchroniser for the monitor pins
`timescale 1ns/100ps
module qsg_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= async_i[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;
endmodule // qsg_sync

// ===== src/qsg_top.sv
// Clock-loss and measurement-doubt status groups with command port
`timescale 1ns/100ps
`include "qsg_map.svh"

// Operation
// RULE1: Clock-loss condition bit 0 follows the error detector clock-loss monitor.
// RULE2: Clock-loss condition bit 1 follows the pattern generator clock-loss monitor.
// RULE3: Clock-loss summary drives doubt condition bits 5 and 9.
// RULE4: Clock-loss condition captures either source and is readable.
// RULE5: Clock-loss event latches filtered changes until cleared.
// RULE6: Enabled latched clock-loss events assert the clock-loss summary.
// RULE7: Clock-loss filter has separate rise and fall masks, like doubt filter.
// RULE8: Each filter bit passes rising, falling or both edges per masks.
// RULE9: After reset rise masks all set, fall masks all clear.
// RULE10: Doubt group registers are 16 bits, condition-filter-event-enable model.
// RULE11: Doubt condition bit 0 shows data loss at error detector.
// RULE12: Data-loss bit also sets when threshold lies outside the eye.
// RULE13: Doubt condition bit 3 shows power loss at either unit.
// RULE14: Doubt condition bit 8 shows calibration mismatch of installed module.
// RULE15: Doubt bit 10 shows pattern mismatch or error rate above sync threshold.
// RULE16: Doubt event latches filtered condition bits and is readable.
// RULE17: Controller reads clock-loss group to find source behind bits 5, 9.
// RULE18: Enabled latched doubt events set doubt summary, status byte bit 3.
// RULE19: Writing a mask replaces it wholly.
// RULE20: Unused bits read zero and ignore writes.
// RULE21: Conditions track monitors each cycle; edges from current versus previous.
// RULE22: Events clear on read; a same-cycle new event survives.
module qsg_top (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ed_clock_lost_i,
  input  wire logic             pg_clock_lost_i,
  input  wire logic             ed_data_lost_i,
  input  wire logic             ed_threshold_outside_eye_i,
  input  wire logic             ed_power_lost_i,
  input  wire logic             pg_power_lost_i,
  input  wire logic             calibration_mismatch_i,
  input  wire logic             pattern_mismatch_i,
  input  wire logic             error_rate_over_sync_i,
  input  wire logic             cmd_valid_i,
  input  wire logic             cmd_write_i,
  input  wire qsg_pkg::qsg_sel_t  cmd_sel_i,
  input  wire qsg_pkg::qsg_word_t cmd_wdata_i,
  output logic                  rsp_valid_o,
  output qsg_pkg::qsg_word_t    rsp_data_o,
  output logic                  clock_loss_summary_o,
  output logic                  doubt_summary_o
);
  import qsg_pkg::*;

  localparam int MON_W = 9;

  // Monitor pins come from other units; synchronise before use
  logic [MON_W-1:0] mon_raw;
  logic [MON_W-1:0] mon_sync;

  assign mon_raw = {error_rate_over_sync_i, pattern_mismatch_i, calibration_mismatch_i,
                    pg_power_lost_i, ed_power_lost_i, ed_threshold_outside_eye_i,
                    ed_data_lost_i, pg_clock_lost_i, ed_clock_lost_i};

  qsg_sync #(
    .WIDTH (MON_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (mon_raw),
    .sync_o  (mon_sync)
  );

  logic s_ed_clk;
  logic s_pg_clk;
  logic s_data;
  logic s_eye;
  logic s_ed_pwr;
  logic s_pg_pwr;
  logic s_calibration_mismatch;
  logic s_pat;
  logic s_ber;

  assign s_ed_clk = mon_sync[0];
  assign s_pg_clk = mon_sync[1];
  assign s_data   = mon_sync[2];
  assign s_eye    = mon_sync[3];
  assign s_ed_pwr = mon_sync[4];
  assign s_pg_pwr = mon_sync[5];
  assign s_calibration_mismatch  = mon_sync[6];
  assign s_pat    = mon_sync[7];
  assign s_ber    = mon_sync[8];

  // Software-visible control registers
  qsg_word_t cl_rise_r;
  qsg_word_t cl_fall_r;
  qsg_word_t cl_enable_r;
  qsg_word_t md_rise_r;
  qsg_word_t md_fall_r;
  qsg_word_t md_enable_r;

  // Summaries and response
  logic      cl_summary_r;
  logic      md_summary_r;
  logic      rsp_valid_r;
  qsg_word_t rsp_data_r;

  // Command decode
  logic cmd_rd;
  logic cmd_wr;
  logic wr_cl_rise;
  logic wr_cl_fall;
  logic wr_cl_enable;
  logic wr_md_rise;
  logic wr_md_fall;
  logic wr_md_enable;
  logic clr_all;
  logic rd_cl_event;
  logic rd_md_event;
  logic cl_event_clr;
  logic md_event_clr;

  assign cmd_rd       = cmd_valid_i & ~cmd_write_i;
  assign cmd_wr       = cmd_valid_i & cmd_write_i;
  assign wr_cl_rise   = cmd_wr & (cmd_sel_i == `QSG_SEL_CL_RISE);
  assign wr_cl_fall   = cmd_wr & (cmd_sel_i == `QSG_SEL_CL_FALL);
  assign wr_cl_enable = cmd_wr & (cmd_sel_i == `QSG_SEL_CL_ENABLE);
  assign wr_md_rise   = cmd_wr & (cmd_sel_i == `QSG_SEL_MD_RISE);
  assign wr_md_fall   = cmd_wr & (cmd_sel_i == `QSG_SEL_MD_FALL);
  assign wr_md_enable = cmd_wr & (cmd_sel_i == `QSG_SEL_MD_ENABLE);
  assign clr_all      = cmd_wr & (cmd_sel_i == `QSG_SEL_CLEAR_ALL);
  assign rd_cl_event  = cmd_rd & (cmd_sel_i == `QSG_SEL_CL_EVENT);
  assign rd_md_event  = cmd_rd & (cmd_sel_i == `QSG_SEL_MD_EVENT);
  // Reading an event register consumes it
  assign cl_event_clr = rd_cl_event | clr_all;                         // RULE22
  assign md_event_clr = rd_md_event | clr_all;                         // RULE22

  // Clock-loss condition inputs
  qsg_word_t cl_cond_in;
  qsg_word_t cl_cond;
  qsg_word_t cl_event;

  always_comb begin
    cl_cond_in                  = `QSG_ZERO16;
    cl_cond_in[`QSG_CL_ED_BIT]  = s_ed_clk;                            // RULE1
    cl_cond_in[`QSG_CL_PG_BIT]  = s_pg_clk;                            // RULE2
  end

  qsg_edge_group #(
    .USED (`QSG_CL_USED)
  ) u_cl_group (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .cond_i      (cl_cond_in),                                         // RULE4
    .rise_mask_i (cl_rise_r),                                          // RULE7
    .fall_mask_i (cl_fall_r),                                          // RULE7
    .event_clr_i (cl_event_clr),
    .cond_o      (cl_cond),
    .event_o     (cl_event)
  );

  // Doubt condition inputs; clock-loss summary feeds two bit positions
  qsg_word_t md_cond_in;
  qsg_word_t md_cond;
  qsg_word_t md_event;

  always_comb begin
    md_cond_in                        = `QSG_ZERO16;
    md_cond_in[`QSG_MD_DATA_LOSS_BIT] = s_data | s_eye;                // RULE11 RULE12
    md_cond_in[`QSG_MD_POWER_BIT]     = s_ed_pwr | s_pg_pwr;           // RULE13
    md_cond_in[`QSG_MD_CLOCK_A_BIT]   = cl_summary_r;                  // RULE3
    md_cond_in[`QSG_MD_CALIBRATION_MISMATCH_BIT]     = s_calibration_mismatch;                       // RULE14
    md_cond_in[`QSG_MD_CLOCK_B_BIT]   = cl_summary_r;                  // RULE3
    md_cond_in[`QSG_MD_SYNC_BIT]      = s_pat | s_ber;                 // RULE15
  end

  qsg_edge_group #(
    .USED (`QSG_MD_USED)
  ) u_md_group (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .cond_i      (md_cond_in),                                         // RULE10
    .rise_mask_i (md_rise_r),
    .fall_mask_i (md_fall_r),
    .event_clr_i (md_event_clr),
    .cond_o      (md_cond),
    .event_o     (md_event)                                            // RULE16
  );

  // Control register writes replace the whole value, unused bits dropped
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cl_rise_r   <= `QSG_CL_RISE_RST;                                 // RULE9
      cl_fall_r   <= `QSG_FALL_RST;                                    // RULE9
      cl_enable_r <= `QSG_ENABLE_RST;
      md_rise_r   <= `QSG_MD_RISE_RST;                                 // RULE9
      md_fall_r   <= `QSG_FALL_RST;                                    // RULE9
      md_enable_r <= `QSG_ENABLE_RST;
    end else begin
      if (wr_cl_rise) begin
        cl_rise_r <= cmd_wdata_i & `QSG_CL_USED;                       // RULE19 RULE20
      end
      if (wr_cl_fall) begin
        cl_fall_r <= cmd_wdata_i & `QSG_CL_USED;                       // RULE19 RULE20
      end
      if (wr_cl_enable) begin
        cl_enable_r <= cmd_wdata_i & `QSG_CL_USED;                     // RULE20
      end
      if (wr_md_rise) begin
        md_rise_r <= cmd_wdata_i & `QSG_MD_USED;                       // RULE19 RULE20
      end
      if (wr_md_fall) begin
        md_fall_r <= cmd_wdata_i & `QSG_MD_USED;                       // RULE19 RULE20
      end
      if (wr_md_enable) begin
        md_enable_r <= cmd_wdata_i & `QSG_MD_USED;                     // RULE20
      end
    end
  end

  // Summaries: any latched event with its enable set
  logic cl_summary_nxt;
  logic md_summary_nxt;

  assign cl_summary_nxt = |(cl_event & cl_enable_r);                   // RULE6
  assign md_summary_nxt = |(md_event & md_enable_r);                   // RULE18

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cl_summary_r <= 1'b0;
      md_summary_r <= 1'b0;
    end else begin
      cl_summary_r <= cl_summary_nxt;
      md_summary_r <= md_summary_nxt;
    end
  end

  // Read mux; unmapped selects answer zero
  qsg_word_t rd_mux;

  always_comb begin
    case (cmd_sel_i)
      `QSG_SEL_CL_COND:   rd_mux = cl_cond;                            // RULE4
      `QSG_SEL_CL_RISE:   rd_mux = cl_rise_r;
      `QSG_SEL_CL_FALL:   rd_mux = cl_fall_r;
      `QSG_SEL_CL_EVENT:  rd_mux = cl_event;
      `QSG_SEL_CL_ENABLE: rd_mux = cl_enable_r;
      `QSG_SEL_MD_COND:   rd_mux = md_cond;
      `QSG_SEL_MD_RISE:   rd_mux = md_rise_r;
      `QSG_SEL_MD_FALL:   rd_mux = md_fall_r;
      `QSG_SEL_MD_EVENT:  rd_mux = md_event;                           // RULE16
      `QSG_SEL_MD_ENABLE: rd_mux = md_enable_r;
      default:            rd_mux = `QSG_ZERO16;                        // RULE20
    endcase
  end

  // The answer holds the pre-clear event value, so the read sees what it consumes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= `QSG_ZERO16;
    end else begin
      rsp_valid_r <= cmd_rd;
      if (cmd_rd) begin
        rsp_data_r <= rd_mux;
      end
    end
  end

  assign rsp_valid_o          = rsp_valid_r;
  assign rsp_data_o           = rsp_data_r;
  assign clock_loss_summary_o = cl_summary_r;
  assign doubt_summary_o      = md_summary_r;
endmodule // qsg_top
